/* rtl/rtbg_ctrl.sv */
// register controller, software end of the link over Avalon-MM
`timescale 1ns/100ps
module rtbg_ctrl (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  rtbg_if.host             link,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq
);
  import rtbg_pkg::*;

  typedef enum {ST_IDLE, ST_LINK, ST_WAIT, ST_RUN, ST_RUN_WAIT, ST_DONE} rtbg_state_type;

  rtbg_state_type            state_r;
  logic [EVT_W-1:0]          status_r;
  logic [EVT_W-1:0]          enable_r;
  logic [7:0]                shadow_r;
  logic [7:0]                code_r;
  logic                      start_r;
  logic                      is_setup_r;
  logic [EVT_W-1:0]          evt;
  logic                      irq_prev_r;
  logic                      tmr_hit;
  logic [2:0]                tmr_idx;
  logic                      refuse;
  logic [2:0]                mode_sel;
  logic                      baud_code;

  assign tmr_idx  = avs_address[4:2];
  assign tmr_hit  = (avs_address[5] == OFS_TIMER[5]) && (tmr_idx <= IDX_RELOAD_HI);
  assign mode_sel = avs_writedata[2:0];
  // stopped timer is safe to touch; baud mode counter access and reload writes are not
  assign refuse = tmr_hit && shadow_r[BIT_RUN]
                  && (shadow_r[BIT_RX_CLK_SEL] | shadow_r[BIT_TX_CLK_SEL])
                  && ((tmr_idx == IDX_CNT_LO) || (tmr_idx == IDX_CNT_HI) // RULE11 RULE13
                      || (avs_write && tmr_idx != IDX_CTRL)); // RULE12
  assign baud_code = code_r[BIT_RX_CLK_SEL] | code_r[BIT_TX_CLK_SEL];

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_r         <= ST_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
      link.sfr_req    <= 1'b0;
      link.sfr_we     <= 1'b0;
      link.sfr_idx    <= IDX_CTRL;
      link.sfr_wdata  <= BYTE_ZERO;
      shadow_r        <= CTRL_RESET;
      code_r          <= CTRL_RESET;
      start_r         <= 1'b0;
      is_setup_r      <= 1'b0;
      evt             <= '0;
    end else begin
      link.sfr_req <= 1'b0;
      evt          <= '0;
      case (state_r)
        ST_IDLE: begin
          if (avs_write && avs_address == OFS_SETUP && mode_sel <= MODE_BAUD_TX) begin
            code_r <= avs_writedata[SETUP_EXT_BIT] ? CODE_EXT[mode_sel] : CODE_INT[mode_sel]; // RULE15
            start_r    <= avs_writedata[SETUP_START_BIT];
            is_setup_r <= 1'b1;
            state_r    <= ST_RUN;
          end else if ((avs_read || avs_write) && tmr_hit && refuse) begin
            evt[EVT_REFUSED] <= 1'b1;
            avs_readdata     <= 32'h0000_0000;
            avs_waitrequest  <= 1'b0;
            state_r          <= ST_DONE;
          end else if ((avs_read || avs_write) && tmr_hit) begin
            link.sfr_req   <= 1'b1;
            link.sfr_we    <= avs_write;
            link.sfr_idx   <= tmr_idx;
            link.sfr_wdata <= avs_writedata[7:0];
            is_setup_r     <= 1'b0;
            if (avs_write && tmr_idx == IDX_CTRL) begin
              shadow_r <= avs_writedata[7:0];
            end
            state_r <= ST_WAIT;
          end else if (avs_read || avs_write) begin
            case (avs_address)
              OFS_STATUS: avs_readdata <= {{(32-EVT_W){1'b0}}, status_r};
              OFS_ENABLE: avs_readdata <= {{(32-EVT_W){1'b0}}, enable_r};
              default:    avs_readdata <= 32'h0000_0000;
            endcase
            avs_waitrequest <= 1'b0;
            state_r         <= ST_DONE;
          end
        end
        ST_RUN: begin
          link.sfr_req   <= 1'b1;
          link.sfr_we    <= 1'b1;
          link.sfr_idx   <= IDX_CTRL;
          link.sfr_wdata <= code_r;
          shadow_r       <= code_r;
          state_r        <= ST_RUN_WAIT;
        end
        ST_RUN_WAIT: begin
          if (link.sfr_ack) begin
            if (start_r && !baud_code) begin
              code_r  <= code_r | RUN_MASK; // RULE14
              start_r <= 1'b0;
              state_r <= ST_RUN;
            end else begin
              evt[EVT_SETUP_DONE] <= 1'b1;
              avs_waitrequest     <= 1'b0;
              state_r             <= ST_DONE;
            end
          end
        end
        ST_WAIT: begin
          if (link.sfr_ack) begin
            avs_readdata    <= {24'h00_0000, link.sfr_rdata};
            avs_waitrequest <= 1'b0;
            state_r         <= ST_DONE;
          end
        end
        ST_DONE: begin
          avs_waitrequest <= 1'b1;
          state_r         <= ST_IDLE;
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

  // sticky events; a new event wins over a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      status_r   <= '0;
      enable_r   <= '0;
      irq_prev_r <= 1'b0;
      irq        <= 1'b0;
    end else begin
      irq_prev_r <= link.timer_irq;
      if (state_r == ST_IDLE && avs_write && avs_address == OFS_ENABLE) begin
        enable_r <= avs_writedata[EVT_W-1:0];
      end
      status_r <= (status_r & ~((state_r == ST_IDLE && avs_write && avs_address == OFS_CLEAR)
                               ? avs_writedata[EVT_W-1:0] : '0))
                  | evt | {{(EVT_W-2){1'b0}}, link.timer_irq & ~irq_prev_r, 1'b0};
      irq <= |(status_r & enable_r);
    end
  end
endmodule // rtbg_ctrl

/* rtl/rtbg_fall_det.sv */
// one-cycle pulse on a falling edge of a synchronous pin
`timescale 1ns/100ps
module rtbg_fall_det (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic pin_in,
  output logic      fall_pulse
);
  logic prev_r;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      prev_r     <= 1'b1;
      fall_pulse <= 1'b0;
    end else begin
      prev_r     <= pin_in;
      fall_pulse <= prev_r & ~pin_in;
    end
  end
endmodule // rtbg_fall_det

/* rtl/rtbg_if.sv */
// link between the timer and its register controller
`timescale 1ns/100ps
interface rtbg_if;
  logic       sfr_req;
  logic       sfr_we;
  logic [2:0] sfr_idx;
  logic [7:0] sfr_wdata;
  logic       sfr_ack;
  logic [7:0] sfr_rdata;
  logic       timer_irq;
  modport dev  (input sfr_req, sfr_we, sfr_idx, sfr_wdata, output sfr_ack, sfr_rdata, timer_irq);
  modport host (output sfr_req, sfr_we, sfr_idx, sfr_wdata, input sfr_ack, sfr_rdata, timer_irq);
endinterface

/* rtl/rtbg_pkg.sv */
// shared constants and types of the reload timer baud generator
package rtbg_pkg;
  // timer register indices on the link
  localparam logic [2:0] IDX_CTRL     = 3'h0;
  localparam logic [2:0] IDX_CNT_LO   = 3'h1;
  localparam logic [2:0] IDX_CNT_HI   = 3'h2;
  localparam logic [2:0] IDX_RELOAD_LO = 3'h3;
  localparam logic [2:0] IDX_RELOAD_HI = 3'h4;
  // timer_ctrl_reg bit positions
  localparam int BIT_OVF_FLAG    = 7;
  localparam int BIT_EXT_FLAG    = 6;
  localparam int BIT_RX_CLK_SEL  = 5;
  localparam int BIT_TX_CLK_SEL  = 4;
  localparam int BIT_EXT_EN      = 3;
  localparam int BIT_RUN         = 2;
  localparam int BIT_CNT_SEL     = 1;
  localparam int BIT_CAPTURE_SEL = 0;
  localparam logic [7:0]  CTRL_RESET  = 8'h00;
  localparam logic [15:0] CNT_RESET   = 16'h0000;
  localparam logic [15:0] CNT_MAX     = 16'hFFFF;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  // core_clk is the oscillator; state time is osc/2, machine cycle osc/12
  localparam logic [3:0]  STATE_DIV   = 4'h2;
  localparam logic [3:0]  MACH_DIV    = 4'hC;
  localparam logic [3:0]  BAUD_DIV    = 4'hF;   // last step of divide by 16
  // set-up codes, indexed by mode and internal or external control
  typedef enum logic [2:0] {
    MODE_AUTO_RELOAD, MODE_CAPTURE, MODE_BAUD_BOTH, MODE_BAUD_RX, MODE_BAUD_TX
  } rtbg_mode_type;
  localparam logic [7:0] CODE_INT [0:4] = '{8'h00, 8'h01, 8'h34, 8'h24, 8'h14};
  localparam logic [7:0] CODE_EXT [0:4] = '{8'h08, 8'h09, 8'h36, 8'h26, 8'h16};
  localparam logic [7:0] RUN_MASK = 8'h04;
  // controller Avalon-MM byte offsets
  localparam logic [5:0] OFS_SETUP   = 6'h00;
  localparam logic [5:0] OFS_STATUS  = 6'h04;
  localparam logic [5:0] OFS_CLEAR   = 6'h08;
  localparam logic [5:0] OFS_ENABLE  = 6'h0C;
  localparam logic [5:0] OFS_TIMER   = 6'h20;   // five words, one per timer register
  localparam int SETUP_EXT_BIT   = 3;
  localparam int SETUP_START_BIT = 4;
  localparam int EVT_REFUSED     = 0;
  localparam int EVT_TIMER_IRQ   = 1;
  localparam int EVT_SETUP_DONE  = 2;
  localparam int EVT_W           = 3;
endpackage

/* rtl/rtbg_timer.sv */
// reload timer with baud generator mode, timer end of the link
// What this block does
// RULE1: transmit clock from other timer or this one
// RULE2: receive clock selected the same way
// RULE3: baud mode rollover reloads both counter bytes
// RULE4: baud rate is overflow rate over 16
// RULE5: baud mode counts osc/2, timer osc/12
// RULE6: internal baud is osc/(32*(65536-reload))
// RULE7: external clock baud is overflows over 16
// RULE8: baud mode rollover sets no overflow flag
// RULE9: baud mode trigger edge sets flag only
// RULE10: baud mode only while a clock select set
// RULE11: software avoids counter access in baud mode
// RULE12: software never writes reload in baud mode
// RULE13: software stops timer before register access
// RULE14: run bit set by separate write
// RULE15: set-up codes per mode and trigger use
// RULE16: no trigger: reload on overflow; capture mode wraps the counter to zero and captures nothing
// RULE17: trigger edge also captures or reloads
// RULE18: count osc/12 or external falling edges
// RULE19: control register bit layout fixed
`timescale 1ns/100ps
module rtbg_timer (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  rtbg_if.dev       link,
  input  wire logic ext_clk_pin,
  input  wire logic ext_trig_pin,
  input  wire logic other_ovf_pulse,
  output logic      tx_baud_tick,
  output logic      rx_baud_tick
);
  import rtbg_pkg::*;

  logic [7:0]  ctrl_r;
  logic [15:0] cnt_r;
  logic [15:0] reload_r;
  logic [3:0]  state_div_r;
  logic [3:0]  mach_div_r;
  logic [3:0]  own_div_r;
  logic [3:0]  other_div_r;
  logic        ext_clk_fall;
  logic        ext_trig_fall;
  logic        baud_mode;
  logic        capture_mode;
  logic        state_tick;
  logic        mach_tick;
  logic        inc;
  logic        ovf;
  logic        ext_evt;
  logic        wr;
  logic        own_tick;
  logic        other_tick;

  rtbg_fall_det u_clk_fall (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .pin_in     (ext_clk_pin),
    .fall_pulse (ext_clk_fall)
  );

  rtbg_fall_det u_trig_fall (
    .core_clk   (core_clk),
    .sys_rst    (sys_rst),
    .pin_in     (ext_trig_pin),
    .fall_pulse (ext_trig_fall)
  );

  assign baud_mode    = ctrl_r[BIT_RX_CLK_SEL] | ctrl_r[BIT_TX_CLK_SEL]; // RULE10
  assign capture_mode = ctrl_r[BIT_CAPTURE_SEL] & ~baud_mode;
  assign state_tick   = (state_div_r == STATE_DIV - 4'h1);
  assign mach_tick    = (mach_div_r == MACH_DIV - 4'h1);
  assign wr           = link.sfr_req & link.sfr_we;

  // internal rate depends on mode; external pin counts falling edges
  always_comb begin
    if (ctrl_r[BIT_CNT_SEL]) begin
      inc = ext_clk_fall; // RULE18 RULE7
    end else if (baud_mode) begin
      inc = state_tick; // RULE5
    end else begin
      inc = mach_tick; // RULE5 RULE18
    end
    inc = inc & ctrl_r[BIT_RUN];
  end

  assign ovf     = inc & (cnt_r == CNT_MAX);
  assign ext_evt = ext_trig_fall & ctrl_r[BIT_EXT_EN];

  // oscillator prescalers, free running so rates stay exact
  always_ff @(posedge core_clk) begin
    if (sys_rst || state_tick) begin
      state_div_r <= 4'h0;
    end else begin
      state_div_r <= state_div_r + 4'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst || mach_tick) begin
      mach_div_r <= 4'h0;
    end else begin
      mach_div_r <= mach_div_r + 4'h1;
    end
  end

  // control register; hardware set wins over a write in the same cycle
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_r <= CTRL_RESET;
    end else begin
      if (wr && link.sfr_idx == IDX_CTRL) begin
        ctrl_r <= link.sfr_wdata; // RULE19
      end
      if (ovf && !baud_mode) begin
        ctrl_r[BIT_OVF_FLAG] <= 1'b1; // RULE8
      end
      if (ext_evt) begin
        ctrl_r[BIT_EXT_FLAG] <= 1'b1; // RULE9
      end
    end
  end

  // counter: software bytes first, counting and reload take priority
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_r <= CNT_RESET;
    end else begin
      if (wr && link.sfr_idx == IDX_CNT_LO) begin
        cnt_r[7:0] <= link.sfr_wdata;
      end
      if (wr && link.sfr_idx == IDX_CNT_HI) begin
        cnt_r[15:8] <= link.sfr_wdata;
      end
      if (ovf && !capture_mode) begin
        cnt_r <= reload_r; // RULE3 RULE16
      end else if (inc) begin
        cnt_r <= cnt_r + 16'h0001;
      end
      if (ext_evt && !baud_mode && !capture_mode) begin
        cnt_r <= reload_r; // RULE17 RULE9
      end
    end
  end

  // reload pair doubles as capture register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      reload_r <= CNT_RESET;
    end else begin
      if (wr && link.sfr_idx == IDX_RELOAD_LO) begin
        reload_r[7:0] <= link.sfr_wdata;
      end
      if (wr && link.sfr_idx == IDX_RELOAD_HI) begin
        reload_r[15:8] <= link.sfr_wdata;
      end
      if (ext_evt && capture_mode) begin
        reload_r <= cnt_r; // RULE17
      end
    end
  end

  // divide by 16 of each overflow source; with osc/2 counting this gives osc/32 per count
  assign own_tick   = ovf & baud_mode & (own_div_r == BAUD_DIV); // RULE4 RULE6
  assign other_tick = other_ovf_pulse & (other_div_r == BAUD_DIV);

  always_ff @(posedge core_clk) begin
    if (sys_rst || !baud_mode) begin
      own_div_r <= 4'h0;
    end else if (ovf) begin
      own_div_r <= own_div_r + 4'h1; // RULE4 RULE7
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      other_div_r <= 4'h0;
    end else if (other_ovf_pulse) begin
      other_div_r <= other_div_r + 4'h1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_baud_tick <= 1'b0;
      rx_baud_tick <= 1'b0;
    end else begin
      tx_baud_tick <= ctrl_r[BIT_TX_CLK_SEL] ? own_tick : other_tick; // RULE1
      rx_baud_tick <= ctrl_r[BIT_RX_CLK_SEL] ? own_tick : other_tick; // RULE2
    end
  end

  // register reads answer one cycle after the request
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      link.sfr_ack   <= 1'b0;
      link.sfr_rdata <= BYTE_ZERO;
    end else begin
      link.sfr_ack <= link.sfr_req;
      case (link.sfr_idx)
        IDX_CTRL:      link.sfr_rdata <= ctrl_r;
        IDX_CNT_LO:    link.sfr_rdata <= cnt_r[7:0];
        IDX_CNT_HI:    link.sfr_rdata <= cnt_r[15:8];
        IDX_RELOAD_LO: link.sfr_rdata <= reload_r[7:0];
        IDX_RELOAD_HI: link.sfr_rdata <= reload_r[15:8];
        default:       link.sfr_rdata <= BYTE_ZERO;
      endcase
    end
  end

  // flags stay set until software clears them
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      link.timer_irq <= 1'b0;
    end else begin
      link.timer_irq <= ctrl_r[BIT_OVF_FLAG] | ctrl_r[BIT_EXT_FLAG];
    end
  end
endmodule // rtbg_timer

/* verif/rtbg_link_assertions.sv */
// link checker between the timer and its register controller
`timescale 1ns/100ps
module rtbg_link_chk (
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic       sfr_req,
  input wire logic       sfr_we,
  input wire logic [2:0] sfr_idx,
  input wire logic [7:0] sfr_wdata,
  input wire logic       sfr_ack,
  input wire logic [7:0] sfr_rdata,
  input wire logic       timer_irq
);
  import rtbg_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] ctrl_r;
  logic [7:0] rlo_r;
  logic [7:0] rhi_r;
  logic       rq_we_r;
  logic [2:0] rq_idx_r;
  logic [1:0] quiet_r;
  logic       rd_ack;
  logic       baud_q;
  assign rd_ack = sfr_ack && !rq_we_r;
  // external trigger may set a flag legally, so only plain baud modes count as quiet
  assign baud_q = ctrl_r[BIT_RUN] && (ctrl_r[BIT_RX_CLK_SEL] || ctrl_r[BIT_TX_CLK_SEL]) && !ctrl_r[BIT_EXT_EN]
                  && ctrl_r[7:6] == 2'h0;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rq_we_r  <= 1'b0;
      rq_idx_r <= 3'h0;
    end else if (sfr_req) begin
      rq_we_r  <= sfr_we;
      rq_idx_r <= sfr_idx;
    end
  end
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      ctrl_r <= 8'h00;
      rlo_r  <= 8'h00;
      rhi_r  <= 8'h00;
    end else if (sfr_req && sfr_we) begin
      if (sfr_idx == IDX_CTRL) ctrl_r <= sfr_wdata;
      if (sfr_idx == IDX_RELOAD_LO) rlo_r <= sfr_wdata;
      if (sfr_idx == IDX_RELOAD_HI) rhi_r <= sfr_wdata;
    end
  end
  // irq lags the flag, so allow three cycles after any write
  always_ff @(posedge core_clk) begin
    if (sys_rst || (sfr_req && sfr_we) || !baud_q) quiet_r <= 2'h0;
    else if (quiet_r != 2'h3) quiet_r <= quiet_r + 2'h1;
  end
  chk_ack_follows:
    assert property (sfr_req |=> sfr_ack) else $error("no answer one cycle after request");
  chk_ack_has_req:
    assert property (sfr_ack |-> $past(sfr_req)) else $error("answer without request");
  chk_req_spacing:
    assert property (sfr_req |=> !sfr_req) else $error("requests closer than two cycles");
  chk_ack_single:
    assert property (sfr_ack |=> !sfr_ack) else $error("answer longer than one cycle");
  chk_ctrl_layout:
    assert property (rd_ack && rq_idx_r == IDX_CTRL |-> sfr_rdata[5:0] == ctrl_r[5:0])
      else $error("control readback differs from written bits");
  chk_reload_read:
    assert property (rd_ack && !ctrl_r[BIT_CAPTURE_SEL] && (rq_idx_r == IDX_RELOAD_LO || rq_idx_r == IDX_RELOAD_HI)
      |-> sfr_rdata == (rq_idx_r == IDX_RELOAD_LO ? rlo_r : rhi_r)) else $error("reload readback wrong");
  chk_baud_no_flag:
    assert property (quiet_r == 2'h3 |-> !timer_irq) else $error("interrupt in plain baud mode");
  chk_irq_tracks_flag:
    assert property (rd_ack && rq_idx_r == IDX_CTRL && sfr_rdata[7:6] != 2'h0 |-> timer_irq)
      else $error("flag set but interrupt low");
  cov_write: cover property (sfr_req && sfr_we);
  cov_irq_read: cover property (rd_ack && timer_irq);
  cov_quiet: cover property (quiet_r == 2'h3);
endmodule // rtbg_link_chk

/* verif/tb_top.sv */
// testbench of both ends of the reload timer baud generator
`timescale 1ns/100ps
module tb_top;
  import rtbg_pkg::*;
  logic        core_clk;
  logic        sys_rst;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic        ext_clk_pin;
  logic        ext_trig_pin;
  logic        other_ovf_pulse;
  logic        tx_baud_tick;
  logic        rx_baud_tick;
  logic [1:0]  tk;
  logic [1:0]  watch;
  logic [15:0] rl;
  logic [31:0] rd_q[$];
  int          per_q[2][$];
  int          last[2];
  int          cyc;
  int          n;
  int          fails;
  int          n_checks;
  assign tk = {rx_baud_tick, tx_baud_tick};
  rtbg_if u_rtbg_if ();
  rtbg_timer u_rtbg_timer (.core_clk(core_clk), .sys_rst(sys_rst), .link(u_rtbg_if), .ext_clk_pin(ext_clk_pin),
    .ext_trig_pin(ext_trig_pin), .other_ovf_pulse(other_ovf_pulse), .tx_baud_tick(tx_baud_tick),
    .rx_baud_tick(rx_baud_tick));
  rtbg_ctrl u_rtbg_ctrl (.core_clk(core_clk), .sys_rst(sys_rst), .link(u_rtbg_if), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
  rtbg_link_chk u_rtbg_link_chk (.core_clk(core_clk), .sys_rst(sys_rst), .sfr_req(u_rtbg_if.sfr_req),
    .sfr_we(u_rtbg_if.sfr_we), .sfr_idx(u_rtbg_if.sfr_idx), .sfr_wdata(u_rtbg_if.sfr_wdata),
    .sfr_ack(u_rtbg_if.sfr_ack), .sfr_rdata(u_rtbg_if.sfr_rdata), .timer_irq(u_rtbg_if.timer_irq));
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic av(input logic [5:0] a, input logic w, input logic [31:0] d);
    @(posedge core_clk);
    avs_address   <= a;
    avs_read      <= !w;
    avs_write     <= w;
    avs_writedata <= d;
    do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    av(a, 1'b1, d);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    av(a, 1'b0, 32'h0);
  endtask
  function automatic logic [5:0] ta(input int i);
    return OFS_TIMER + 6'(4 * i);
  endfunction
  // first tick after a mode change may be short, so only whole intervals count
  task automatic measure(input int ptx, input int prx);
    repeat (3) begin
      per_q[0].push_back(ptx);
      per_q[1].push_back(prx);
    end
    watch = 2'b11;
    while (per_q[0].size() + per_q[1].size() > 0) @(posedge core_clk);
    watch = 2'b00;
  endtask
  task automatic baud(input int m, input logic x, input int ptx, input int prx);
    wr(OFS_SETUP, 32'(m) | (x ? 32'h8 : 32'h0));
    measure(ptx, prx);
  endtask
  // one falling edge on the trigger pin, settled before the next access
  task automatic trig;
    ext_trig_pin <= 1'b0;
    repeat (3) @(posedge core_clk);
    ext_trig_pin <= 1'b1;
    repeat (3) @(posedge core_clk);
  endtask
  always @(posedge core_clk)
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) cmp("readdata", rd_q.pop_front(), avs_readdata);
  always @(posedge core_clk) begin
    for (int i = 0; i < 2; i++) begin
      if (watch[i] !== 1'b1) last[i] = 0;
      else if (tk[i] === 1'b1) begin
        if (last[i] > 0 && per_q[i].size() > 0) cmp("tick period", per_q[i].pop_front(), cyc - last[i]);
        last[i] = cyc;
      end
    end
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    ext_clk_pin <= cyc[2];
    other_ovf_pulse <= (cyc % 20 == 0);
    if (cyc == 40000) begin
      fails++;
      test_done;
    end
  end
  always #5 core_clk = ~core_clk;
  initial begin
    core_clk = 1'b0;
    sys_rst = 1'b1;
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    {ext_trig_pin, watch} = 3'h4;
    void'($urandom(42));
    rl = 16'hFFF8 | 16'($urandom % 8);
    n = 65536 - int'(rl);
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    rd(OFS_STATUS, 32'h0);
    rd(ta(0), 32'h0);
    rd(6'h3C, 32'h0);
    for (int x = 0; x < 2; x++)
      for (int m = 0; m < 5; m++) begin
        wr(OFS_SETUP, 32'(m + 8 * x));
        rd(ta(0), 32'(x ? CODE_EXT[m] : CODE_INT[m]));
      end
    wr(OFS_SETUP, 32'h0);
    for (int i = 1; i < 5; i++) wr(ta(i), 32'(i % 2 ? rl[7:0] : rl[15:8]));
    rd(ta(1), {24'h00_0000, rl[7:0]});
    rd(ta(2), {24'h00_0000, rl[15:8]});
    baud(2, 1'b0, 32 * n, 32 * n);
    baud(4, 1'b0, 32 * n, 320);
    baud(3, 1'b0, 320, 32 * n);
    baud(2, 1'b1, 128 * n, 128 * n);
    wr(OFS_ENABLE, 32'h2);
    // set-up codes leave the trigger off in baud mode, so enable it by hand
    wr(ta(0), 32'h0000_003E);
    trig;
    measure(128 * n, 128 * n);
    rd(ta(0), 32'h0000_007E);
    rd(OFS_STATUS, 32'h6);
    cmp("irq", 32'h1, {31'h0, irq});
    rd(ta(1), 32'h0);
    wr(ta(3), 32'h55);
    rd(ta(3), {24'h0, rl[7:0]});
    rd(OFS_STATUS, 32'h7);
    wr(OFS_ENABLE, 32'h0);
    repeat (2) @(posedge core_clk);
    cmp("irq", 32'h0, {31'h0, irq});
    wr(OFS_CLEAR, 32'h7);
    rd(OFS_STATUS, 32'h0);
    wr(OFS_SETUP, 32'h10);
    repeat (120) @(posedge core_clk);
    rd(ta(0), 32'h84);
    // second write lands with the timer stopped, so no overflow flag slips in
    repeat (2) wr(ta(0), 32'h0000_0008);
    wr(ta(1), 32'h0000_0000);
    trig;
    rd(ta(1), {24'h00_0000, rl[7:0]});
    rd(ta(0), 32'h0000_0048);
    wr(ta(0), 32'h0000_0009);
    wr(ta(1), 32'h0000_005A);
    trig;
    rd(ta(3), 32'h0000_005A);
    test_done;
  end
endmodule // tb_top
